// file: hdl/pmte_pkg.sv
`default_nettype none
package pmte_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_COMMAND = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;
    localparam logic [7:0] OFF_SYNC = 8'h10;
    // field positions
    localparam int CMD_TASK_W = 4;
    localparam int SB_BUFFER_FREE_FLAG = 7;
    localparam int SB_IRQ = 6;
    localparam int SB_CHKERR = 5;
    localparam int SB_LINKDIR = 4;
    localparam int MODE_TX = 0;
    localparam int MODE_IRQEN = 1;
    // task codes, receive mode
    localparam logic [3:0] TASK_NULL = 4'h0;
    localparam logic [3:0] TASK_SEARCH_HEAD = 4'h1;
    localparam logic [3:0] TASK_READ_HEAD_RAW = 4'h2;
    localparam logic [3:0] TASK_READ_BLOCK = 4'h3;
    localparam logic [3:0] TASK_SEARCH_SYNC = 4'h4;
    localparam logic [3:0] TASK_READ_ONE_BYTE = 4'h5;
    localparam logic [3:0] TASK_LOAD_SYNC = 4'h6;
    localparam logic [3:0] TASK_RESET = 4'h7;
    localparam logic [3:0] TASK_SEARCH_HEAD_EXACT = 4'h9;
    localparam logic [3:0] TASK_READ_SHORT_BLOCK = 4'hB;
    localparam logic [3:0] TASK_SEARCH_SYNC_EXACT = 4'hC;
    // task codes, transmit mode
    localparam logic [3:0] TASK_SEND_HEAD = 4'h1;
    // bit counts of the tasks, buffer depth in bytes, sync bit error limit
    localparam logic [7:0] HEAD_BITS = 8'h18;
    localparam logic [7:0] BLOCK_BITS = 8'hF0;
    localparam logic [7:0] BLOCK_CRC_BITS = 8'hA0;
    localparam logic [7:0] SHORT_BITS = 8'h48;
    localparam logic [7:0] SHORT_CRC_BITS = 8'h30;
    localparam logic [7:0] BYTE_BITS = 8'h08;
    localparam logic [5:0] HEAD_TX_BITS = 6'h38;
    localparam logic [4:0] BUF_DEPTH = 5'h12;
    localparam logic [4:0] SYNC_MAX_ERR = 5'h01;
    // reset values and crc
    localparam logic [15:0] SYNC_RESET = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef enum logic [1:0] {
        PMTE_IDLE,
        PMTE_SEARCH,
        PMTE_RXBITS,
        PMTE_BUFLOAD
    } pmte_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pmte_apb_in_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pmte_apb_out_t;
endpackage
`default_nettype wire

// file: hdl/pmte_core.sv
// Function
// R1: in transmit the host fills the buffer from byte 0, then writes the task
// R2: writing a data task clears buffer_free_flag at once
// R3: transmit data moves to the interleave shifter when it is empty
// R4: buffer emptied sets buffer_free_flag and irq; pin low if enabled
// R5: receive task waits for bits, fills buffer, sets buffer_free_flag and irq
// R6: host reads of the data buffer return byte 0 then the following bytes
// R7: host loads both sync pattern bytes before writing load_sync_pattern
// R8: host issues load_sync_pattern only between received messages
// R9: no_operation leaves the running task untouched
// R10: search_frame_head matches the 16-bit sync with at most one bad bit
// R11: after sync match, read 3 head bytes, keep data, flag fec errors
// R12: on sync match link_direction_flag follows the 3 bits before it
// R13: read_head_raw stores 3 raw bytes and flags fec mismatch
// R14: read_block takes 240 bits, stores 18 bytes, flags crc failure
// R15: read_short_block takes 72 bits, stores 4 bytes, flags crc failure; code stores all 9 bytes
// R16: crc logic is re-initialised whenever a non-null task completes
// R17: search_sync only sets flags and link direction on a match
// R18: exact search variants demand all 16 sync bits to match
// R19: read_one_byte packs 8 bits, earliest bit into bit 7
// R20: load_sync_pattern takes byte 0 as msb half, byte 1 as lsb half
// R21: send_frame_head takes 6 bytes and appends an 8-bit check byte
// R22: send_frame_head sends byte 0 bit 7 first, check byte bit 0 last
// R23: transmit data tasks take their payload from the data buffer
// R24: the 4-bit task field selects tasks per mode; other codes reserved
// R25: reset task ends any task, sets buffer_free_flag, leaves irq alone
// R26: reserved codes change neither task nor status flags
`default_nettype none
module pmte_core (
    input wire logic i_sys_clk,                   // system clock
    input wire logic i_arst_n,                    // async reset, active low
    input wire pmte_pkg::pmte_apb_in_t i_apb,     // apb request
    output var pmte_pkg::pmte_apb_out_t o_apb,    // apb answer
    input wire logic i_rx_bit,                    // demodulated bit
    input wire logic i_rx_bit_valid,              // one-cycle bit strobe
    output logic o_tx_bit,                        // bit to modulator
    output logic o_tx_bit_valid,                  // tx bit present
    input wire logic i_tx_ready,                  // modulator takes bit
    output logic o_interrupt_request_low          // interrupt, active low
);
    import pmte_pkg::*;

    typedef struct packed {
        pmte_state_t st;
        logic [3:0] task_code;
        logic tx_mode;
        logic irq_en;
        logic buffer_free_flag;
        logic irq;
        logic chk_err;
        logic link_dir;
        logic irq_n;
        logic [15:0] sync;
        logic [18:0] hist;
        logic [7:0] cnt;
        logic [7:0] byte_sr;
        logic [15:0] crc;
        logic [BUF_DEPTH-1:0][7:0] dbuf;
        logic [4:0] wptr;
        logic [4:0] rptr;
        logic [55:0] txsh;
        logic [5:0] txcnt;
        logic tx_busy;
        pmte_apb_out_t apb;
    } pmte_regs_t;

    pmte_regs_t s;
    pmte_regs_t n;

    function automatic logic [4:0] mism_cnt(input logic [15:0] x);
        logic [4:0] k;
        k = '0;
        for (int i = 0; i < 16; i++) begin
            k = k + {4'h0, x[i]};
        end
        return k;
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction

    // 8-bit check byte over the two head control bytes
    function automatic logic [7:0] head_fec(input logic [7:0] a,
                                            input logic [7:0] b);
        return a ^ {b[3:0], b[7:4]} ^ {a[0], a[7:1]};
    endfunction

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [7:0] rx_len(input logic [3:0] t);
        case (t)
            TASK_READ_BLOCK: return BLOCK_BITS;
            TASK_READ_SHORT_BLOCK: return SHORT_BITS;
            TASK_READ_ONE_BYTE: return BYTE_BITS;
            default: return HEAD_BITS;
        endcase
    endfunction

    function automatic logic [7:0] crc_len(input logic [3:0] t);
        case (t)
            TASK_READ_BLOCK: return BLOCK_CRC_BITS;
            TASK_READ_SHORT_BLOCK: return SHORT_CRC_BITS;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic data_task(input logic [3:0] t,
                                       input logic tx);
        if (tx) begin
            return t == TASK_SEND_HEAD;
        end
        case (t)
            TASK_SEARCH_HEAD, TASK_READ_HEAD_RAW, TASK_READ_BLOCK,
            TASK_SEARCH_SYNC, TASK_READ_ONE_BYTE, TASK_LOAD_SYNC,
            TASK_SEARCH_HEAD_EXACT, TASK_READ_SHORT_BLOCK,
            TASK_SEARCH_SYNC_EXACT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a == OFF_COMMAND || a == OFF_DATA || a == OFF_STATUS ||
               a == OFF_MODE || a == OFF_SYNC;
    endfunction

    logic setup;
    logic acc_rd;
    logic acc_wr;
    logic cmd_wr;
    logic [3:0] code;
    logic [18:0] hist_nx;
    logic exact;
    logic sync_only;
    logic match;
    logic [7:0] rx_byte;
    logic rx_done;
    logic [7:0] rd_byte;

    assign setup = i_apb.psel & ~i_apb.penable;
    assign acc_rd = i_apb.psel & i_apb.penable & s.apb.pready & ~i_apb.pwrite;
    assign acc_wr = i_apb.psel & i_apb.penable & s.apb.pready & i_apb.pwrite;
    assign cmd_wr = acc_wr && i_apb.paddr == OFF_COMMAND;
    assign code = i_apb.pwdata[CMD_TASK_W-1:0]; // R24
    assign hist_nx = {s.hist[17:0], i_rx_bit};
    assign exact = s.task_code == TASK_SEARCH_HEAD_EXACT ||
                   s.task_code == TASK_SEARCH_SYNC_EXACT;
    assign sync_only = s.task_code == TASK_SEARCH_SYNC ||
                       s.task_code == TASK_SEARCH_SYNC_EXACT;
    // tolerant search allows one bad bit, exact search none
    assign match = i_rx_bit_valid &&
                   mism_cnt(hist_nx[15:0] ^ s.sync) <=
                   (exact ? 5'h00 : SYNC_MAX_ERR); // R10 R18
    assign rx_byte = {s.byte_sr[6:0], i_rx_bit}; // R19
    assign rx_done = s.st == PMTE_RXBITS && i_rx_bit_valid &&
                     s.cnt + 8'h01 == rx_len(s.task_code);
    assign rd_byte = (s.rptr < BUF_DEPTH) ? s.dbuf[s.rptr] : 8'h00;

    always_comb begin
        logic fin;
        fin = 1'b0;
        n = s;
        // bus answer is registered: pready rises in the access phase
        n.apb.pready = setup;
        n.apb.pslverr = setup && !addr_ok(i_apb.paddr);
        n.apb.prdata = '0;
        if (setup && !i_apb.pwrite) begin
            case (i_apb.paddr)
                OFF_DATA: n.apb.prdata[7:0] = rd_byte;
                OFF_STATUS: begin
                    n.apb.prdata[SB_BUFFER_FREE_FLAG] = s.buffer_free_flag;
                    n.apb.prdata[SB_IRQ] = s.irq;
                    n.apb.prdata[SB_CHKERR] = s.chk_err;
                    n.apb.prdata[SB_LINKDIR] = s.link_dir;
                end
                OFF_MODE: begin
                    n.apb.prdata[MODE_TX] = s.tx_mode;
                    n.apb.prdata[MODE_IRQEN] = s.irq_en;
                end
                OFF_SYNC: n.apb.prdata[15:0] = s.sync;
                default: ;
            endcase
        end
        if (acc_rd && i_apb.paddr == OFF_DATA && s.rptr < BUF_DEPTH) begin
            n.rptr = s.rptr + 5'h01; // R6
        end
        // status read clears irq; a set in the same cycle wins below
        if (acc_rd && i_apb.paddr == OFF_STATUS) begin
            n.irq = 1'b0;
        end
        if (s.tx_busy && i_tx_ready) begin
            n.txsh = {s.txsh[54:0], 1'b0}; // R22
            n.txcnt = s.txcnt - 6'h01;
            n.tx_busy = s.txcnt != 6'h01;
        end
        if (i_rx_bit_valid) begin
            n.hist = hist_nx;
        end
        case (s.st)
            PMTE_IDLE: ;
            PMTE_SEARCH: begin
                if (match) begin
                    n.link_dir = maj3(hist_nx[18:16]); // R12
                    n.cnt = '0;
                    if (sync_only) begin
                        fin = 1'b1; // R17
                    end else begin
                        n.st = PMTE_RXBITS; // R11
                    end
                end
            end
            PMTE_RXBITS: begin
                if (i_rx_bit_valid) begin
                    n.byte_sr = rx_byte;
                    if (s.cnt < crc_len(s.task_code)) begin
                        n.crc = crc_step(s.crc, i_rx_bit); // R14 R15
                    end
                    if (s.cnt[2:0] == 3'h7 && s.cnt[7:3] < BUF_DEPTH) begin
                        n.dbuf[s.cnt[7:3]] = rx_byte; // R5
                    end
                    n.cnt = s.cnt + 8'h01;
                end
                if (rx_done) begin
                    fin = 1'b1;
                    case (s.task_code)
                        TASK_READ_BLOCK, TASK_READ_SHORT_BLOCK:
                            n.chk_err = s.crc != 16'h0000; // R14 R15
                        TASK_READ_ONE_BYTE: ;
                        default: n.chk_err = rx_byte !=
                            head_fec(s.dbuf[0], s.dbuf[1]); // R11 R13
                    endcase
                end
            end
            PMTE_BUFLOAD: begin
                if (!s.tx_mode) begin
                    n.sync = {s.dbuf[0], s.dbuf[1]}; // R20
                    fin = 1'b1;
                end else if (!s.tx_busy) begin
                    n.txsh = {s.dbuf[0], s.dbuf[1], s.dbuf[2], s.dbuf[3],
                              s.dbuf[4], s.dbuf[5],
                              head_fec(s.dbuf[4], s.dbuf[5])}; // R21 R23
                    n.txcnt = HEAD_TX_BITS;
                    n.tx_busy = 1'b1; // R3
                    fin = 1'b1;
                end
            end
            default: n.st = PMTE_IDLE;
        endcase
        if (fin) begin
            n.buffer_free_flag = 1'b1; // R4 R5
            n.irq = 1'b1;
            n.st = PMTE_IDLE;
            n.crc = CRC_INIT; // R16
            n.rptr = '0;
        end
        if (cmd_wr) begin
            if (code == TASK_RESET) begin
                n.st = PMTE_IDLE; // R25
                n.irq = s.irq;
                n.buffer_free_flag = 1'b1;
                n.tx_busy = 1'b0;
                n.txcnt = '0;
                n.cnt = '0;
                n.crc = CRC_INIT;
            end else if (data_task(code, s.tx_mode)) begin // R9 R26
                n.task_code = code;
                n.buffer_free_flag = 1'b0; // R2
                n.chk_err = 1'b0;
                n.cnt = '0;
                n.wptr = '0;
                n.rptr = '0;
                if (s.tx_mode || code == TASK_LOAD_SYNC) begin
                    n.st = PMTE_BUFLOAD;
                end else if (code == TASK_READ_HEAD_RAW ||
                             code == TASK_READ_BLOCK ||
                             code == TASK_READ_ONE_BYTE ||
                             code == TASK_READ_SHORT_BLOCK) begin
                    n.st = PMTE_RXBITS;
                end else begin
                    n.st = PMTE_SEARCH;
                end
            end
        end
        if (acc_wr && i_apb.paddr == OFF_DATA && s.wptr < BUF_DEPTH) begin
            n.dbuf[s.wptr] = i_apb.pwdata[7:0];
            n.wptr = s.wptr + 5'h01;
        end
        if (acc_wr && i_apb.paddr == OFF_MODE) begin
            n.tx_mode = i_apb.pwdata[MODE_TX];
            n.irq_en = i_apb.pwdata[MODE_IRQEN];
        end
        n.irq_n = ~(n.irq & n.irq_en); // R4
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
            s.buffer_free_flag <= 1'b1;
            s.irq_n <= 1'b1;
            s.sync <= SYNC_RESET;
            s.crc <= CRC_INIT;
        end else begin
            s <= n;
        end
    end

    assign o_apb = s.apb;
    assign o_tx_bit = s.txsh[55];
    assign o_tx_bit_valid = s.tx_busy;
    assign o_interrupt_request_low = s.irq_n;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    property p_cmd_buffer_free_flag;
        cmd_wr && data_task(code, s.tx_mode) |=> !s.buffer_free_flag;
    endproperty
    a_cmd_buffer_free_flag: assert property (p_cmd_buffer_free_flag) // R2
        else $error("data task did not clear buffer free");

    property p_reset_task;
        cmd_wr && code == TASK_RESET |=> s.buffer_free_flag && s.st == PMTE_IDLE &&
            !s.tx_busy && s.irq == $past(s.irq);
    endproperty
    a_reset_task: assert property (p_reset_task) // R25
        else $error("reset task misbehaved");

    property p_null_keeps;
        cmd_wr && !data_task(code, s.tx_mode) && code != TASK_RESET |=>
            $stable(s.task_code) && (!$past(s.buffer_free_flag) || s.buffer_free_flag);
    endproperty
    a_null_keeps: assert property (p_null_keeps) // R9 R26
        else $error("null or reserved code changed the task");

    property p_tx_load;
        s.st == PMTE_BUFLOAD && s.tx_mode && !s.tx_busy && !cmd_wr |=>
            s.tx_busy && s.txcnt == HEAD_TX_BITS && s.buffer_free_flag && s.irq;
    endproperty
    a_tx_load: assert property (p_tx_load) // R3
        else $error("frame head not loaded when shifter idle");

    property p_irq_pin;
        $rose(s.irq) && s.irq_en |-> !o_interrupt_request_low ##1
            (o_interrupt_request_low == !(s.irq && s.irq_en));
    endproperty
    a_irq_pin: assert property (p_irq_pin) // R4
        else $error("interrupt pin does not follow irq");

    property p_link;
        s.st == PMTE_SEARCH && match && !cmd_wr |=>
            s.st != PMTE_SEARCH && s.link_dir == maj3($past(hist_nx[18:16]));
    endproperty
    a_link: assert property (p_link) // R10 R12
        else $error("sync match not acted on");

    property p_exact;
        s.st == PMTE_SEARCH && exact && i_rx_bit_valid &&
            hist_nx[15:0] != s.sync && !cmd_wr |=> s.st == PMTE_SEARCH;
    endproperty
    a_exact: assert property (p_exact) // R18
        else $error("exact search accepted a bad bit");

    property p_rx_done;
        rx_done && !cmd_wr |=> s.buffer_free_flag && s.irq && s.st == PMTE_IDLE &&
            s.crc == CRC_INIT;
    endproperty
    a_rx_done: assert property (p_rx_done) // R5 R16
        else $error("receive completion flags wrong");

    property p_rptr;
        acc_rd && i_apb.paddr == OFF_DATA && s.rptr < BUF_DEPTH && !rx_done
            |=> s.rptr == $past(s.rptr) + 5'h01;
    endproperty
    a_rptr: assert property (p_rptr) // R6
        else $error("data read pointer did not advance");

    property p_tx_order;
        s.tx_busy && i_tx_ready && s.txcnt > 6'h01 |=>
            o_tx_bit == $past(s.txsh[54]) && o_tx_bit_valid;
    endproperty
    a_tx_order: assert property (p_tx_order) // R22
        else $error("tx bit order wrong");

    property p_one_byte;
        rx_done && s.task_code == TASK_READ_ONE_BYTE && !acc_wr |=>
            s.dbuf[0] == $past(rx_byte);
    endproperty
    a_one_byte: assert property (p_one_byte) // R19
        else $error("single byte packed wrong");

    property p_sync_load;
        s.st == PMTE_BUFLOAD && !s.tx_mode && !cmd_wr |=>
            s.sync[15:8] == $past(s.dbuf[0]) &&
            s.sync[7:0] == $past(s.dbuf[1]) && s.buffer_free_flag;
    endproperty
    a_sync_load: assert property (p_sync_load) // R20
        else $error("sync pattern load wrong");
endmodule // pmte_core
`default_nettype wire

// file: hdl/pmte_hdr_placeholder_none.sv
`default_nettype none
`default_nettype wire

// file: testbench/pmte_radio_model.sv
`default_nettype none
module pmte_radio_model (
    input wire logic i_clk,      // system clock
    input wire logic i_tx_bit,   // bit from the modem
    input wire logic i_tx_valid, // tx bit present
    output logic o_rx_bit,       // demodulated bit
    output logic o_rx_valid,     // one-cycle bit strobe
    output logic o_tx_ready      // modulator takes the bit
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 87363;
    logic got [$];
    initial begin
        o_rx_bit = 1'b0;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b0;
    end
    // one strobe per bit; a released line shows the inverse, never the bit
    task automatic send(input logic b);
        @(posedge i_clk);
        o_rx_bit <= b;
        o_rx_valid <= 1'b1;
        @(posedge i_clk);
        o_rx_bit <= ~b;
        o_rx_valid <= 1'b0;
    endtask
    // slow modulator: ready drops at random to stall the shifter
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready)
            got.push_back(i_tx_bit);
        o_tx_ready <= ($random(seed) & 3) != 0;
    end
endmodule // pmte_radio_model
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmte_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    pmte_apb_in_t apb_in = '0;
    pmte_apb_out_t apb_out;
    logic rx_bit, rx_vld, tx_bit, tx_vld, tx_rdy, irq_n;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    integer seed = 87363;
    logic [31:0] rd;
    logic err, cur_dir;
    logic [15:0] pat;
    logic [0:239] bv;
    always #2.5 i_sys_clk = ~i_sys_clk;
    pmte_core dut (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_apb(apb_in),
        .o_apb(apb_out), .i_rx_bit(rx_bit), .i_rx_bit_valid(rx_vld),
        .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_vld), .i_tx_ready(tx_rdy),
        .o_interrupt_request_low(irq_n));
    pmte_radio_model radio (
        .i_clk(i_sys_clk), .i_tx_bit(tx_bit), .i_tx_valid(tx_vld),
        .o_rx_bit(rx_bit), .o_rx_valid(rx_vld), .o_tx_ready(tx_rdy));
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask
    function automatic logic [31:0] st(input logic bf, iq, ce, ld);
        return {24'h0, bf, iq, ce, ld, 4'h0};
    endfunction
    function automatic logic [7:0] chkb(input logic [7:0] a, b);
        return a ^ {b[3:0], b[7:4]} ^ {a[0], a[7:1]};
    endfunction
    function automatic logic [15:0] crc(input logic [0:239] b, input int n);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < n; i++)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    // one apb transfer, an idle cycle after it
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        apb_in.psel <= 1'b1;
        apb_in.penable <= 1'b0;
        apb_in.pwrite <= wr;
        apb_in.paddr <= a;
        apb_in.pwdata <= wd;
        @(posedge i_sys_clk);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic cmd(input logic [3:0] c);
        apb(1'b1, OFF_COMMAND, {28'h0, c});
    endtask
    task automatic send_bits(input int n);
        for (int i = 0; i < n; i++)
            radio.send(bv[i]);
    endtask
    task automatic rdbytes(input int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b0, OFF_DATA, 32'h0);
            chk(rd, {24'h0, bv[8*i +: 8]});
        end
    endtask
    // three direction bits, then the pattern with bit k inverted
    task automatic sync_seq(input logic [2:0] d, input int k);
        for (int i = 2; i >= 0; i--)
            radio.send(d[i]);
        for (int i = 15; i >= 0; i--)
            radio.send(pat[i] ^ (i == k));
        cur_dir = (d[0] & d[1]) | (d[0] & d[2]) | (d[1] & d[2]);
    endtask
    task automatic done(input logic ce);
        int n;
        n = 0;
        while (irq_n !== 1'b0 && n < 3000) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk({31'h0, irq_n}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b1, ce, cur_dir));
        chk({31'h0, irq_n}, 32'h1);
    endtask
    task automatic head(input logic [3:0] c, input int k, input logic bad);
        logic [7:0] a, b;
        logic [2:0] d;
        a = $random(seed);
        b = $random(seed);
        d = $random(seed);
        bv[0 +: 24] = {a, b, chkb(a, b) ^ {7'h0, bad}};
        cmd(c);
        if (c != TASK_READ_HEAD_RAW)
            sync_seq(d, k);
        send_bits(24);
        done(bad);
        rdbytes(3);
    endtask
    task automatic blk(input logic [3:0] c, input int n, input int m,
        input int nb, input logic bad);
        for (int i = 0; i < n; i++)
            bv[i] = $random(seed);
        if (m > 0)
            bv[m-16 +: 16] = crc(bv, m - 16);
        bv[3] = bv[3] ^ bad;
        cmd(c);
        send_bits(n);
        done(bad);
        rdbytes(nb);
    endtask
    initial begin
        int n;
        pat = 16'h7A91;
        cur_dir = 1'b0;
        repeat (6) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        @(posedge i_sys_clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b0, 1'b0, 1'b0));
        apb(1'b0, OFF_MODE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'b1, OFF_DATA, {24'h0, pat[15:8]});
        apb(1'b1, OFF_DATA, {24'h0, pat[7:0]});
        cmd(TASK_LOAD_SYNC);
        repeat (2) @(posedge i_sys_clk);
        chk({31'h0, irq_n}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b1, 1'b0, 1'b0));
        apb(1'b0, OFF_SYNC, 32'h0);
        chk(rd, {16'h0, pat});
        apb(1'b1, OFF_MODE, 32'h2);
        cmd(TASK_SEARCH_SYNC);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b0, 1'b0, 1'b0, 1'b0));
        sync_seq(3'b110, {$random(seed)} % 16);
        done(1'b0);
        cmd(TASK_SEARCH_SYNC_EXACT);
        cmd(TASK_NULL);
        cmd(4'h8);
        sync_seq(3'b001, 5);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd & 32'hE0, 32'h0);
        sync_seq(3'b011, 16);
        done(1'b0);
        cmd(TASK_SEARCH_HEAD);
        cmd(TASK_RESET);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b0, 1'b0, cur_dir));
        head(TASK_SEARCH_HEAD, {$random(seed)} % 16, 1'b0);
        head(TASK_READ_HEAD_RAW, 16, 1'b1);
        head(TASK_SEARCH_HEAD_EXACT, 16, 1'b0);
        blk(TASK_READ_BLOCK, 240, 160, 18, 1'b0);
        blk(TASK_READ_SHORT_BLOCK, 72, 48, 4, 1'b1);
        blk(TASK_READ_SHORT_BLOCK, 72, 48, 4, 1'b0);
        blk(TASK_READ_ONE_BYTE, 8, 0, 1, 1'b0);
        apb(1'b1, OFF_MODE, 32'h3);
        for (int i = 0; i < 6; i++) begin
            bv[8*i +: 8] = $random(seed);
            apb(1'b1, OFF_DATA, {24'h0, bv[8*i +: 8]});
        end
        bv[48 +: 8] = chkb(bv[32 +: 8], bv[40 +: 8]);
        cmd(TASK_SEND_HEAD);
        done(1'b0);
        n = 0;
        while (radio.got.size() < 56 && n < 3000) begin
            @(posedge i_sys_clk);
            n++;
        end
        for (int i = 0; i < 56; i++)
            chk({31'h0, radio.got[i]}, {31'h0, bv[i]});
        @(posedge i_sys_clk);
        chk({31'h0, tx_vld}, 32'h0);
        cmd(TASK_READ_BLOCK);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b0, 1'b0, cur_dir));
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
